// ===== rtl/eeld_regs.svh
// Purpose: constants of the eeprom conditional loader
// Assumes: included by bare name from rtl/
// Notes:   definitions only
`ifndef EELD_REGS_SVH
`define EELD_REGS_SVH
// ----------------------------------------
// instruction codes
// ----------------------------------------
`define EELD_OP_XFER_MAX  8'h7F
`define EELD_OP_COND_BASE 8'hB0
`define EELD_OP_COND_HI   4'hB
`define EELD_OP_PAUSE     8'hFE
`define EELD_OP_END       8'hFF
// ----------------------------------------
// reset values, timing counts and device address
// ----------------------------------------
`define EELD_PTR_RST      16'h0000
`define EELD_CSUM_RST     8'h00
`define EELD_ARB_SCL_CYC  8'hFF
`define EELD_QTR_CYC      8'h14
`define EELD_DEV_ADDR     7'h50
`endif

// ===== rtl/eeld_pkg.sv
// Purpose: types of the eeprom conditional loader
// Assumes: constants live in eeld_regs.svh
// Notes:   all state records are packed structs
package eeld_pkg;
  // ----------------------------------------
  // state machines
  // ----------------------------------------
  typedef enum logic [2:0] {
    M_IDLE = 3'b000, M_RD = 3'b001, M_WAIT = 3'b010, M_DEC = 3'b011, M_UGET = 3'b100
  } eeld_mst_type;
  typedef enum logic [1:0] {
    PH_OP = 2'b00, PH_AH = 2'b01, PH_AL = 2'b10, PH_DAT = 2'b11
  } eeld_ph_type;
  typedef enum logic [2:0] {
    L_IDLE = 3'b000, L_WAIT = 3'b001, L_START = 3'b010, L_BIT = 3'b011, L_STOP = 3'b100
  } eeld_lst_type;
  // ----------------------------------------
  // crossing records
  // ----------------------------------------
  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } eeld_req_type;
  typedef struct packed {
    logic       nack;
    logic [7:0] rdata;
  } eeld_rsp_type;
  // ----------------------------------------
  // module state
  // ----------------------------------------
  typedef struct packed {
    eeld_mst_type st;
    eeld_ph_type  ph;
    logic         ul;
    logic         chk;
    logic         fin;
    logic         csw;
    logic [15:0]  ptr;
    logic [7:0]   csum;
    logic [15:0]  cmap;
    logic [7:0]   len;
    logic [15:0]  wadr;
    logic         xq;
    logic [7:0]   byt;
    eeld_req_type req;
    logic         req_t;
    logic         ack_s1;
    logic         ack_s2;
    logic         ack_seen;
    logic         wr_stb;
    logic [15:0]  wr_addr;
    logic [7:0]   wr_data;
    logic         act_stb;
    logic [7:0]   act_code;
    logic         done;
    logic         csum_err;
    logic         nack_err;
  } eeld_mstate_type;
  typedef struct packed {
    eeld_lst_type st;
    logic [1:0]   qp;
    logic [7:0]   cnt;
    logic [2:0]   idx;
    logic [3:0]   bitn;
    logic [8:0]   sh;
    logic [7:0]   rx;
    logic         txb;
    logic         ak;
    logic         rs;
    logic         scl_oe;
    logic         sda_oe;
    logic         busy;
    logic         scl_p;
    logic         sda_p;
    logic [7:0]   tmr;
    logic         req_s1;
    logic         req_s2;
    logic         req_seen;
    logic         ack_t;
    eeld_req_type req;
    eeld_rsp_type rsp;
    logic         ce_s1;
    logic         ce_s2;
    logic         scl_s1;
    logic         scl_s2;
    logic         sda_s1;
    logic         sda_s2;
  } eeld_lstate_type;
endpackage : eeld_pkg

// ===== rtl/eeld_i2c_link.sv
// Purpose: i2c master for single-byte eeprom reads and writes, on the link clock
// Assumes: requests arrive by toggle handshake from the loader clock domain
// Notes:   watches the bus for start and stop and backs off on contention
`timescale 1ns/100ps
`include "eeld_regs.svh"
module eeld_i2c_link #(
  parameter logic [7:0] QTR_CYC  = `EELD_QTR_CYC,
  parameter logic [6:0] DEV_ADDR = `EELD_DEV_ADDR
) (
  input  wire logic                  LCLK,
  input  wire logic                  RST,
  input  wire logic                  CE_I,
  input  wire logic                  REQ_T,
  input  wire eeld_pkg::eeld_req_type REQ,
  output      logic                  ACK_T,
  output      eeld_pkg::eeld_rsp_type RSP,
  input  wire logic                  SCL_I,
  input  wire logic                  SDA_I,
  output      logic                  SCL_OE,
  output      logic                  SDA_OE
);
  eeld_pkg::eeld_lstate_type q, d;
  logic rst_s1, rst_s2, lrst;
  logic scl, sda, go, tick, start_seen, stop_seen, scl_rise, new_req;

  // ----------------------------------------
  // byte of the transaction at a position
  // ----------------------------------------
  function automatic logic [7:0] pick(input logic [2:0] i, input eeld_pkg::eeld_req_type r);
    pick = {DEV_ADDR, 1'b0};
    if (i == 3'd1) pick = r.addr[15:8];
    else if (i == 3'd2) pick = r.addr[7:0];
    else if (i == 3'd3) pick = r.wr ? r.wdata : {DEV_ADDR, 1'b1};
  endfunction : pick

  // ----------------------------------------
  // next state
  // ----------------------------------------
  assign lrst       = rst_s2;
  assign scl        = q.scl_s2;
  assign sda        = q.sda_s2;
  assign go         = q.ce_s2;
  assign tick       = q.cnt == QTR_CYC - 8'h01;
  assign start_seen = q.scl_p & scl & q.sda_p & ~sda;
  assign stop_seen  = q.scl_p & scl & ~q.sda_p & sda;
  assign scl_rise   = ~q.scl_p & scl;
  assign new_req    = q.req_s2 != q.req_seen;

  always_comb begin
    d        = q;
    d.ce_s1  = CE_I;
    d.ce_s2  = q.ce_s1;
    d.scl_s1 = SCL_I;
    d.scl_s2 = q.scl_s1;
    d.sda_s1 = SDA_I;
    d.sda_s2 = q.sda_s1;
    d.req_s1 = REQ_T;
    d.req_s2 = q.req_s1;
    if (go) begin
      d.scl_p = scl;
      d.sda_p = sda;
      if (start_seen) d.busy = 1'b1;
      else if (stop_seen) d.busy = 1'b0;
      // stretching: hold the quarter while scl is held low by others
      if (q.st inside {eeld_pkg::L_START, eeld_pkg::L_BIT, eeld_pkg::L_STOP} && !(q.qp == 2'd1 && !scl)) begin
        d.cnt = tick ? 8'h00 : q.cnt + 8'h01;
        if (tick) d.qp = q.qp + 2'd1;
      end
      case (q.st)
        eeld_pkg::L_IDLE: begin
          d.cnt = 8'h00;
          d.qp  = 2'd0;
          if (new_req) begin
            d.req_seen = q.req_s2;
            d.req      = REQ;
            d.rsp.nack = 1'b0;
            d.idx      = 3'd0;
            d.rs       = 1'b0;
            d.tmr      = 8'h00;
            d.st       = (q.busy || !scl) ? eeld_pkg::L_WAIT : eeld_pkg::L_START;
          end
        end
        eeld_pkg::L_WAIT: begin
          d.cnt = 8'h00;
          d.qp  = 2'd0;
          if (stop_seen) begin
            d.st  = eeld_pkg::L_START;
            d.tmr = 8'h00;
          end else if (scl_rise) begin
            d.tmr = q.tmr + 8'h01;
            if (q.tmr == `EELD_ARB_SCL_CYC - 8'h01) begin
              d.tmr = 8'h00;
              d.st  = eeld_pkg::L_START;
            end
          end
        end
        eeld_pkg::L_START: begin
          if (q.qp == 2'd0 && q.cnt == 8'h00 && !q.rs && (!scl || !sda)) begin
            d.st  = eeld_pkg::L_WAIT;
            d.tmr = 8'h00;
          end else if (q.qp == 2'd3 && tick) begin
            d.st   = eeld_pkg::L_BIT;
            d.sh   = {pick(q.idx, q.req), 1'b1};
            d.bitn = 4'd0;
            d.txb  = 1'b1;
          end
        end
        eeld_pkg::L_BIT: begin
          if (q.qp == 2'd2 && tick) begin
            if (q.bitn == 4'd8) d.ak = sda;
            else d.rx = {q.rx[6:0], sda};
            // contention: intended high, seen low
            if (q.txb && q.bitn != 4'd8 && q.sh[8] && !sda) begin
              d.st  = eeld_pkg::L_WAIT;
              d.idx = 3'd0;
              d.rs  = 1'b0;
              d.tmr = 8'h00;
            end
          end else if (q.qp == 2'd3 && tick) begin
            d.bitn = q.bitn + 4'd1;
            d.sh   = {q.sh[7:0], 1'b1};
            if (q.bitn == 4'd8) begin
              d.bitn = 4'd0;
              if (q.txb && q.ak) begin
                d.rsp.nack = 1'b1;
                d.st       = eeld_pkg::L_STOP;
              end else if (q.idx == 3'd4) begin
                d.rsp.rdata = q.rx;
                d.st        = eeld_pkg::L_STOP;
              end else if (q.idx == 3'd3 && q.req.wr) begin
                d.st = eeld_pkg::L_STOP;
              end else if (q.idx == 3'd2 && !q.req.wr) begin
                d.idx = 3'd3;
                d.rs  = 1'b1;
                d.st  = eeld_pkg::L_START;
              end else begin
                d.idx = q.idx + 3'd1;
                d.txb = q.idx != 3'd3;
                d.sh  = (q.idx == 3'd3) ? 9'h1FF : {pick(q.idx + 3'd1, q.req), 1'b1};
              end
            end
          end
        end
        eeld_pkg::L_STOP: begin
          if (q.qp == 2'd3 && tick) begin
            d.st    = eeld_pkg::L_IDLE;
            d.ack_t = ~q.ack_t;
          end
        end
        default: d.st = eeld_pkg::L_IDLE;
      endcase
    end
    d.scl_oe = (d.qp == 2'd0 && (d.st == eeld_pkg::L_BIT || d.st == eeld_pkg::L_STOP ||
               (d.st == eeld_pkg::L_START && d.rs))) ||
               (d.qp == 2'd3 && (d.st == eeld_pkg::L_BIT || d.st == eeld_pkg::L_START));
    d.sda_oe = (d.st == eeld_pkg::L_START && d.qp[1]) || (d.st == eeld_pkg::L_BIT && !d.sh[8]) ||
               (d.st == eeld_pkg::L_STOP && d.qp != 2'd3);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge LCLK) begin
    rst_s1 <= RST;
    rst_s2 <= rst_s1;
  end
  always_ff @(posedge LCLK) begin
    if (lrst) begin
      q        <= '0;
      // idle bus levels, so no false edge or low scl follows reset
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.scl_p  <= 1'b1;
      q.sda_p  <= 1'b1;
    end else q <= d;
  end
  assign ACK_T  = q.ack_t;
  assign RSP    = q.rsp;
  assign SCL_OE = q.scl_oe;
  assign SDA_OE = q.sda_oe;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_busy_track: assert property (@(posedge LCLK) disable iff (lrst)
    go && start_seen |=> q.busy) else $error("bus busy not set on start");
  chk_arb_release: assert property (@(posedge LCLK) disable iff (lrst)
    go && q.st == eeld_pkg::L_BIT && q.qp == 2'd2 && tick && q.txb && q.bitn != 4'd8 && q.sh[8] && !sda
    |=> q.st == eeld_pkg::L_WAIT && !SDA_OE && !SCL_OE) else $error("bus kept after lost arbitration");
  chk_hold_off: assert property (@(posedge LCLK) disable iff (lrst)
    go && q.st == eeld_pkg::L_IDLE && new_req && (!scl || q.busy) |=> q.st == eeld_pkg::L_WAIT)
    else $error("start attempted on occupied bus");
  chk_stop_retry: assert property (@(posedge LCLK) disable iff (lrst)
    go && q.st == eeld_pkg::L_WAIT && stop_seen |=> q.st == eeld_pkg::L_START) else $error("no retry after stop");
  chk_arb_timer: assert property (@(posedge LCLK) disable iff (lrst)
    go && q.st == eeld_pkg::L_WAIT && !stop_seen && scl_rise && q.tmr == 8'hFE
    |=> q.st == eeld_pkg::L_START && q.tmr == 8'h00) else $error("arbitration timer did not force retry");
endmodule : eeld_i2c_link

// ===== rtl/eeld_loader.sv
// Purpose: eeprom instruction sequencer with conditional download, pause, end of data
// Assumes: start strobes, condition id and upload bytes come from logic on CLK
// Notes:   the i2c side runs on LCLK; one byte per toggle handshake
// Functional notes
// - conditional and end-of-data instructions always act during download
// - empty map or zero id executes every instruction
// - nonzero id found in map executes following instructions
// - nonzero id absent from map skips until clear or matching condition
// - map holds many condition values, accumulating until cleared
// - pause works only in upload, goes idle, keeps the pointer
// - upload end writes end code plus checksum, pointer zero, idle
// - download end zeroes pointer, checks stored checksum, goes idle
// - watch sda and scl for start and stop, track bus busy
// - hold a pending transfer on a busy bus until stop
// - sda low while intending high means lost arbitration, abandon at once
// - scl low before start means another master, hold off
// - the winning master finishes its transaction, then stop
// - a postponed transfer retries as soon as a stop is seen
// - timer forces a retry after 255 scl cycles without stop, restarts
// - condition value is instruction code minus base code, zero to fifteen
// - nonzero conditional value is added to the map during download
// - zero conditional value empties the map, unconditional execution follows
// - condition id is a four-bit software field
`timescale 1ns/100ps
`include "eeld_regs.svh"
module eeld_loader #(
  parameter logic [7:0] QTR_CYC  = `EELD_QTR_CYC,
  parameter logic [6:0] DEV_ADDR = `EELD_DEV_ADDR
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic        LCLK,
  input  wire logic        DL_START,
  input  wire logic        UL_START,
  input  wire logic [3:0]  COND_ID,
  input  wire logic [7:0]  UL_DATA,
  input  wire logic        UL_VALID,
  output      logic        UL_READY,
  output      logic        WR_STB,
  output      logic [15:0] WR_ADDR,
  output      logic [7:0]  WR_DATA,
  output      logic        ACT_STB,
  output      logic [7:0]  ACT_CODE,
  output      logic        BUSY,
  output      logic        DONE,
  output      logic        CSUM_ERR,
  output      logic        NACK_ERR,
  output      logic [15:0] EE_PTR,
  input  wire logic        SCL_I,
  output      logic        SCL_O,
  output      logic        SCL_OE,
  input  wire logic        SDA_I,
  output      logic        SDA_O,
  output      logic        SDA_OE
);
  eeld_pkg::eeld_mstate_type q, d;
  eeld_pkg::eeld_rsp_type    rsp;
  logic                      ack_t;
  logic                      exec;
  logic                      ack_ev;
  logic [7:0]                cval;

  // ----------------------------------------
  // i2c side
  // ----------------------------------------
  eeld_i2c_link #(
    .QTR_CYC  (QTR_CYC),
    .DEV_ADDR (DEV_ADDR)
  ) u_link (
    .LCLK   (LCLK),
    .RST    (RST),
    .CE_I   (CE),
    .REQ_T  (q.req_t),
    .REQ    (q.req),
    .ACK_T  (ack_t),
    .RSP    (rsp),
    .SCL_I  (SCL_I),
    .SDA_I  (SDA_I),
    .SCL_OE (SCL_OE),
    .SDA_OE (SDA_OE)
  );
  // open drain: only ever pulls low
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;

  // ----------------------------------------
  // condition evaluation
  // ----------------------------------------
  // the map is a bit per value, so accumulation costs no search
  assign exec   = (COND_ID == 4'h0) || (q.cmap == 16'h0000) || q.cmap[COND_ID];
  assign cval   = q.byt - `EELD_OP_COND_BASE;
  assign ack_ev = q.ack_s2 != q.ack_seen;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    d         = q;
    d.wr_stb  = 1'b0;
    d.act_stb = 1'b0;
    d.done    = 1'b0;
    d.ack_s1  = ack_t;
    d.ack_s2  = q.ack_s1;
    case (q.st)
      eeld_pkg::M_IDLE: begin
        if (DL_START || UL_START) begin
          d.ul       = !DL_START;
          d.st       = DL_START ? eeld_pkg::M_RD : eeld_pkg::M_UGET;
          d.ph       = eeld_pkg::PH_OP;
          d.chk      = 1'b0;
          d.fin      = 1'b0;
          d.csw      = 1'b0;
          d.csum_err = 1'b0;
          d.nack_err = 1'b0;
          if (DL_START) d.cmap = 16'h0000;
          // a paused upload carries its running checksum on
          if (q.ptr == `EELD_PTR_RST) d.csum = `EELD_CSUM_RST;
        end
      end
      eeld_pkg::M_RD: begin
        d.req   = '{wr: 1'b0, addr: q.ptr, wdata: 8'h00};
        d.req_t = ~q.req_t;
        d.st    = eeld_pkg::M_WAIT;
      end
      eeld_pkg::M_WAIT: begin
        if (ack_ev) begin
          d.ack_seen = q.ack_s2;
          if (rsp.nack) begin
            d.nack_err = 1'b1;
            d.done     = 1'b1;
            d.st       = eeld_pkg::M_IDLE;
          end else if (!q.ul) begin
            d.byt = rsp.rdata;
            d.ptr = q.ptr + 16'h0001;
            d.st  = eeld_pkg::M_DEC;
          end else if (q.csw) begin
            d.ptr  = `EELD_PTR_RST;
            d.done = 1'b1;
            d.st   = eeld_pkg::M_IDLE;
          end else if (q.fin) begin
            d.ptr   = q.ptr + 16'h0001;
            d.req   = '{wr: 1'b1, addr: q.ptr + 16'h0001, wdata: q.csum};
            d.req_t = ~q.req_t;
            d.csw   = 1'b1;
          end else begin
            d.ptr = q.ptr + 16'h0001;
            d.st  = eeld_pkg::M_UGET;
          end
        end
      end
      eeld_pkg::M_DEC: begin
        d.st = eeld_pkg::M_RD;
        if (q.chk) begin
          d.csum_err = q.byt != q.csum;
          d.ptr      = `EELD_PTR_RST;
          d.done     = 1'b1;
          d.st       = eeld_pkg::M_IDLE;
        end else begin
          d.csum = q.csum + q.byt;
          case (q.ph)
            eeld_pkg::PH_OP: begin
              if (q.byt <= `EELD_OP_XFER_MAX) begin
                d.len = q.byt;
                d.xq  = exec;
                d.ph  = eeld_pkg::PH_AH;
              end else if (q.byt[7:4] == `EELD_OP_COND_HI) begin
                if (cval[3:0] == 4'h0) d.cmap = 16'h0000;
                else d.cmap[cval[3:0]] = 1'b1;
              end else if (q.byt == `EELD_OP_END) begin
                d.chk = 1'b1;
              end else if (q.byt != `EELD_OP_PAUSE && exec) begin
                // pause means nothing during download
                d.act_stb  = 1'b1;
                d.act_code = q.byt;
              end
            end
            eeld_pkg::PH_AH: begin
              d.wadr[15:8] = q.byt;
              d.ph         = eeld_pkg::PH_AL;
            end
            eeld_pkg::PH_AL: begin
              d.wadr[7:0] = q.byt;
              d.ph        = eeld_pkg::PH_DAT;
            end
            default: begin
              d.wr_stb  = q.xq;
              d.wr_addr = q.wadr;
              d.wr_data = q.byt;
              d.wadr    = q.wadr + 16'h0001;
              d.len     = q.len - 8'h01;
              if (q.len == 8'h00) d.ph = eeld_pkg::PH_OP;
            end
          endcase
        end
      end
      eeld_pkg::M_UGET: begin
        if (UL_VALID) begin
          if (UL_DATA == `EELD_OP_PAUSE) begin
            d.done = 1'b1;
            d.st   = eeld_pkg::M_IDLE;
          end else begin
            d.req   = '{wr: 1'b1, addr: q.ptr, wdata: UL_DATA};
            d.req_t = ~q.req_t;
            d.csum  = q.csum + UL_DATA;
            d.fin   = UL_DATA == `EELD_OP_END;
            d.st    = eeld_pkg::M_WAIT;
          end
        end
      end
      default: d.st = eeld_pkg::M_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) q <= '0;
    else if (CE) q <= d;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign UL_READY = q.st == eeld_pkg::M_UGET;
  assign WR_STB   = q.wr_stb;
  assign WR_ADDR  = q.wr_addr;
  assign WR_DATA  = q.wr_data;
  assign ACT_STB  = q.act_stb;
  assign ACT_CODE = q.act_code;
  assign BUSY     = q.st != eeld_pkg::M_IDLE;
  assign DONE     = q.done;
  assign CSUM_ERR = q.csum_err;
  assign NACK_ERR = q.nack_err;
  assign EE_PTR   = q.ptr;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_op;
    CE && q.st == eeld_pkg::M_DEC && !q.chk && q.ph == eeld_pkg::PH_OP;
  endsequence
  chk_cond_set: assert property (
    s_op and (q.byt[7:4] == 4'hB && q.byt[3:0] != 4'h0) |=> q.cmap[$past(q.byt[3:0])])
    else $error("condition value not added to map");
  chk_map_accum: assert property (
    s_op and (q.byt[7:4] == 4'hB && q.byt[3:0] != 4'h0) |=> (q.cmap & $past(q.cmap)) == $past(q.cmap))
    else $error("map lost an earlier condition");
  chk_cond_clear: assert property (
    s_op and (q.byt == 8'hB0) |=> q.cmap == 16'h0000 && q.st == eeld_pkg::M_RD)
    else $error("zero condition did not clear map");
  chk_exec_all: assert property (
    s_op and (q.byt <= 8'h7F && (COND_ID == 4'h0 || q.cmap == 16'h0000)) |=> q.xq)
    else $error("transfer skipped without condition");
  chk_exec_match: assert property (
    s_op and (q.byt <= 8'h7F && COND_ID != 4'h0 && q.cmap[COND_ID]) |=> q.xq)
    else $error("matching condition skipped");
  chk_skip_nomatch: assert property (
    s_op and (q.byt <= 8'h7F && COND_ID != 4'h0 && q.cmap != 16'h0000 && !q.cmap[COND_ID])
    |=> !q.xq ##0 q.ph == eeld_pkg::PH_AH) else $error("non-matching transfer executed");
  chk_skip_nowrite: assert property (
    CE && q.st == eeld_pkg::M_DEC && !q.chk && q.ph == eeld_pkg::PH_DAT && !q.xq
    |=> !WR_STB && q.st == eeld_pkg::M_RD) else $error("skipped payload written or not read");
  chk_pause_ptr: assert property (
    CE && q.st == eeld_pkg::M_UGET && UL_VALID && UL_DATA == 8'hFE
    |=> q.st == eeld_pkg::M_IDLE && DONE && EE_PTR == $past(EE_PTR)) else $error("pause lost pointer");
  chk_ul_end: assert property (
    CE && q.st == eeld_pkg::M_WAIT && q.ul && ack_ev && !rsp.nack && q.fin && !q.csw
    |=> q.req.wr && q.req.wdata == $past(q.csum) && q.csw) else $error("checksum not written after end");
  chk_ul_ptr: assert property (
    CE && q.st == eeld_pkg::M_WAIT && q.ul && ack_ev && !rsp.nack && q.csw
    |=> EE_PTR == 16'h0000 && q.st == eeld_pkg::M_IDLE) else $error("upload end kept pointer");
  chk_dl_end: assert property (
    CE && q.st == eeld_pkg::M_DEC && q.chk
    |=> EE_PTR == 16'h0000 && !BUSY && CSUM_ERR == ($past(q.byt) != $past(q.csum)))
    else $error("download end wrong");
  cov_dl_ok: cover property (CE && q.st == eeld_pkg::M_DEC && q.chk ##1 DONE && !CSUM_ERR);
  cov_ul_end: cover property (CE && q.ul && q.csw ##[1:400] DONE);
  cov_skip: cover property (CE && q.st == eeld_pkg::M_DEC && q.ph == eeld_pkg::PH_DAT && !q.xq);
endmodule : eeld_loader

// ===== tb/eeld_eeprom.sv
// Purpose: behavioural i2c eeprom, 256 bytes
// Assumes: open-drain lines with pull-up
// Notes:   acks every device address; no stretching
`timescale 1ns/100ps
module eeld_eeprom (
  input  wire logic SCL,
  input  wire logic SDA,
  output      logic SDA_OE
);
  logic [7:0]  mem [0:255];
  logic [7:0]  sh, rb;
  logic [15:0] a;
  logic        rd = 0;
  int          n = 0, k = 0;
  initial SDA_OE = 0;
  always @(negedge SDA) if (SCL) begin
    n = 0;
    k = 0;
    rd = 0;
  end
  always @(posedge SCL) begin
    sh = {sh[6:0], SDA};
    n++;
  end
  always @(negedge SCL) begin
    if (n == 9) begin
      n = 0;
      k++;
    end
    if (n == 8 && !(rd && k > 0)) begin
      case (k)
        0: begin
          rd = sh[0];
          rb = mem[a[7:0]];
        end
        1: a[15:8] = sh;
        2: a[7:0] = sh;
        default: begin
          mem[a[7:0]] = sh;
          a++;
        end
      endcase
      SDA_OE <= 1;
    end else SDA_OE <= rd && k == 1 && n < 8 && !rb[7-n];
  end
endmodule : eeld_eeprom

// ===== tb/eeld_loader_tb.sv
// Purpose: self-checking bench for the eeprom conditional loader
// Assumes: one eeprom, pull-ups, short bit quarters
// Notes:   reset held longer so the link domain sees it
`timescale 1ns/100ps
module eeld_loader_tb;
  logic        clk = 0, rst = 1, lclk = 0, dl = 0, ul = 0, ulv = 0, fsda = 0, fscl = 0;
  logic [3:0]  cid = 0;
  logic [7:0]  uld = 0, img [$];
  logic [31:0] r = 32'h5020;
  logic [23:0] eq [$];
  int          n_fail = 0, checked = 0;
  wire         wr, act, done, cerr, nerr, rdy, scl_oe, sda_oe, ee_oe, bsy;
  wire  [15:0] wa, ptr;
  wire  [7:0]  wd, ac;
  wire         scl = !(scl_oe || fscl);
  wire         sda = !(sda_oe || ee_oe || fsda);
  always #10 clk = ~clk;
  initial begin
    #3.3;
    forever #62.5 lclk = ~lclk;
  end
  eeld_loader #(.QTR_CYC(8'h01)) dut (.CLK(clk), .RST(rst), .CE(1'b1), .LCLK(lclk), .DL_START(dl),
    .UL_START(ul), .COND_ID(cid), .UL_DATA(uld), .UL_VALID(ulv), .UL_READY(rdy), .WR_STB(wr), .WR_ADDR(wa),
    .WR_DATA(wd), .ACT_STB(act), .ACT_CODE(ac), .BUSY(bsy), .DONE(done), .CSUM_ERR(cerr), .NACK_ERR(nerr),
    .EE_PTR(ptr), .SCL_I(scl), .SCL_O(), .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(), .SDA_OE(sda_oe));
  eeld_eeprom ee (.SCL(scl), .SDA(sda), .SDA_OE(ee_oe));
  function automatic logic [7:0] rb();
    repeat (8) r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
    return r[7:0];
  endfunction : rb
  task automatic cmp(input string s, input logic [23:0] e, g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask : cmp
  task automatic print_verdict;
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic wait_done;
    int t = 0;
    // done may already stand when called right after a take
    while (done !== 1'b1 && t < 50000) begin
      @(negedge clk);
      t++;
    end
    if (done !== 1'b1) n_fail++;
    @(negedge clk);
  endtask : wait_done
  task automatic run_dl(input logic [3:0] id, input logic bad);
    int          p = 0;
    logic [15:0] m = 0;
    logic        x;
    while (img[p] != 8'hFF) begin
      x = id == 0 || m == 0 || m[id];
      if (img[p] <= 8'h7F) begin
        for (int i = 0; i <= img[p]; i++) if (x) eq.push_back({{img[p+1], img[p+2]} + 16'(i), img[p+3+i]});
        p += 4 + img[p];
      end else begin
        if (img[p][7:4] == 4'hB) m = img[p] == 8'hB0 ? 16'h0000 : m | 16'h0001 << img[p][3:0];
        else if (x) eq.push_back({16'h0000, img[p]});
        p++;
      end
    end
    ee.mem[img.size()-1] = img[$] ^ {7'h00, bad};
    cid = id;
    dl = 1;
    @(negedge clk) dl = 0;
    wait_done;
    cmp("errors", {bad, 1'b0}, {cerr, nerr});
    cmp("pointer", 0, ptr);
    cmp("busy", 0, bsy);
    cmp("pending", 0, 24'(eq.size()));
  endtask : run_dl
  task automatic ul_byte(input logic [7:0] b);
    @(negedge clk);
    uld = b;
    ulv = 1;
    while (rdy !== 1'b1) @(negedge clk);
    @(negedge clk) ulv = 0;
  endtask : ul_byte
  always @(negedge clk) begin
    if (wr === 1'b1) cmp("write", eq.size() ? eq.pop_front() : 'x, {wa, wd});
    if (act === 1'b1) cmp("action", eq.size() ? eq.pop_front() : 'x, {16'h0000, ac});
  end
  initial begin
    logic [7:0] s = 0;
    img = {8'h00, rb(), rb(), rb(), 8'hB1, 8'h00, rb(), rb(), rb(), 8'hB3, 8'h91, 8'hB0, 8'h80, 8'hFF};
    foreach (img[i]) s += img[i];
    img.push_back(s);
    foreach (img[i]) ee.mem[i] = img[i];
    repeat (24) @(negedge clk);
    rst = 0;
    repeat (20) @(negedge clk);
    fsda = 1;
    repeat (50) @(negedge clk);
    fork begin
      repeat (100) @(negedge clk);
      // another master clocks while holding sda; 271 keeps the eeprom off sda at the end
      repeat (271) begin
        fscl = 1;
        repeat (15) @(negedge clk);
        fscl = 0;
        repeat (15) @(negedge clk);
      end
      cmp("held", 0, {scl_oe, sda_oe});
      foreach (img[i]) ee.mem[i] = img[i];
      fsda = 0;
      @(posedge scl_oe);
      @(negedge clk) fsda = 1;
      repeat (60) @(negedge clk);
      cmp("lost", 0, {scl_oe, sda_oe});
      fsda = 0;
    end join_none
    run_dl(3, 0);
    run_dl(2, 1);
    s = 0;
    ul = 1;
    @(negedge clk) ul = 0;
    for (int i = 0; i < 6; i++) begin
      if (i == 3) begin
        ul_byte(8'hFE);
        wait_done;
        cmp("pause_ptr", 3, ptr);
        ul = 1;
        @(negedge clk) ul = 0;
      end
      img[i] = i == 5 ? 8'hFF : rb() & 8'h7F;
      s += img[i];
      ul_byte(img[i]);
    end
    wait_done;
    cmp("end_ptr", 0, ptr);
    for (int i = 0; i < 7; i++) cmp("stored", i == 6 ? s : img[i], ee.mem[i]);
    print_verdict;
  end
  initial begin
    #1_900_000;
    n_fail++;
    print_verdict;
  end
endmodule : eeld_loader_tb
